// ### saq_pkg.sv
// shared constants and types for the converter sequencer
package saq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int NUM_AUTO = 11;
  localparam logic [4:0] AUTO_LAST = 5'h0A;
  localparam int CNT_W = 16;
  localparam int SLOT_W = 14;

  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHSEL = 8'h04;
  localparam logic [7:0] OFS_TEN = 8'h08;
  localparam logic [7:0] OFS_TSMP = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_LAST = 8'h1C;
  localparam logic [7:0] OFS_RES0 = 8'h40;

  // field positions
  localparam int CTRL_W = 4;
  localparam int ST_CONV_BIT = 0;
  localparam int ST_SWEEP_BIT = 1;
  localparam int STAT_W = 2;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] TEN_RST = 16'h0010;
  localparam logic [15:0] TSMP_RST = 16'h0008;
  localparam logic [1:0] MASK_RST = 2'h0;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_CYC = 12;
  localparam int INTA_CYC = 2;
  localparam int CH_PERIOD_NS = 63330;
  localparam int CH_PERIOD_CYC = (CH_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int FULL_SCALE_MV = 1200;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_RROBIN = 2'h1,
    MODE_ONCE = 2'h2
  } saq_mode_t;

  typedef struct packed {
    logic cont;
    saq_mode_t mode;
    logic en;
  } saq_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ENWAIT = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_CONVERT = 3'h2,
    ST_INTA = 3'h6,
    ST_SLOT = 3'h7
  } saq_state_t;
endpackage : saq_pkg

// ### saq_sar_engine.sv
// successive-approximation bit search, fixed length per conversion
`timescale 1ns/1ps
module saq_sar_engine (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic go,
  input wire logic clr,
  // comparator side
  input wire logic cmp_hi,
  output logic [saq_pkg::RES_W-1:0] dac_code,
  // result
  output logic busy,
  output logic done,
  output logic [saq_pkg::RES_W-1:0] result
);
  logic [3:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [saq_pkg::RES_W-1:0] code_q;
  logic [saq_pkg::RES_W-1:0] res_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      code_q <= 10'h000;
      res_q <= 10'h000;
    end else if (clr) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (go) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
        code_q <= 10'h200;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        // the trial bit stays only while the input is above the dac
        if (cnt_q < 4'hA) begin
          if (!cmp_hi) code_q[4'h9 - cnt_q] <= 1'b0;
          if (cnt_q < 4'h9) code_q[4'h8 - cnt_q] <= 1'b1;
        end
        // the go and done flops fill two of the twelve convert cycles
        if (cnt_q == 4'(saq_pkg::CONV_CYC - 3)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          // bit 0 is decided on this edge, so it comes from cmp_hi directly
          res_q <= {code_q[saq_pkg::RES_W-1:1], cmp_hi};
        end
      end
    end
  end

  assign dac_code = code_q;
  assign busy = busy_q;
  assign done = done_q;
  assign result = res_q;

  chk_conv_twelve: assert property (@(posedge mclk) disable iff (!rst_n || clr)
    go |-> ##11 done) else $error("conversion did not end after 12 cycles");
endmodule : saq_sar_engine

// ### saq_sequencer.sv
// converter sequencer: modes, timing, results, interrupts, register port
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module saq_sequencer #(
  parameter int CH_PERIOD_CYC = saq_pkg::CH_PERIOD_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [saq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [saq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [saq_pkg::DATA_W-1:0] reg_rdata,
  // analog multiplexer and converter
  output logic [saq_pkg::CH_W-1:0] mux_sel,
  output logic sample_en,
  output logic [saq_pkg::RES_W-1:0] dac_code,
  input wire logic cmp_hi,
  // core interrupts
  output logic done_irq,
  output logic irq
);
  logic rst_meta_q;
  logic rst_sync_q;
  saq_pkg::saq_ctrl_t ctrl_q;
  logic [saq_pkg::CH_W-1:0] chsel_q;
  logic [15:0] ten_q;
  logic [15:0] tsmp_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [saq_pkg::RES_W-1:0] last_q;
  logic [saq_pkg::CH_W-1:0] last_ch_q;
  logic [saq_pkg::RES_W-1:0] res_q [0:saq_pkg::NUM_AUTO-1];
  logic [saq_pkg::DATA_W-1:0] rdata_q;
  saq_pkg::saq_state_t state_q;
  saq_pkg::saq_mode_t run_mode_q;
  logic [saq_pkg::CH_W-1:0] ch_q;
  logic [saq_pkg::CNT_W-1:0] cnt_q;
  logic [saq_pkg::SLOT_W-1:0] slot_q;
  logic warm_q;
  logic once_done_q;
  logic single_req_q;
  logic go_q;
  logic abort;
  logic auto_run;
  logic slot_end;
  logic sweep_end;
  logic conv_done;
  logic sar_done;
  logic sar_busy;
  logic [saq_pkg::RES_W-1:0] sar_result;
  logic ctrl_wr;
  logic [1:0] stat_set;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // result window decode; any offset past channel 10 is not a result
  function automatic logic res_hit(input logic [7:0] a);
    logic [7:0] top;
    top = saq_pkg::OFS_RES0 + 8'(4 * saq_pkg::NUM_AUTO);
    res_hit = (a >= saq_pkg::OFS_RES0) && (a < top) && (a[1:0] == 2'h0);
  endfunction : res_hit

  function automatic logic [3:0] res_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - saq_pkg::OFS_RES0;
    res_idx = d[5:2];
  endfunction : res_idx

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign ctrl_wr = reg_wr && hit(reg_addr, saq_pkg::OFS_CTRL);

  // configuration registers
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= saq_pkg::CTRL_RST;
      chsel_q <= 5'h00;
      ten_q <= saq_pkg::TEN_RST;
      tsmp_q <= saq_pkg::TSMP_RST;
      mask_q <= saq_pkg::MASK_RST;
    end else if (reg_wr) begin
      if (ctrl_wr) begin
        ctrl_q.en <= reg_wdata[0];
        ctrl_q.cont <= reg_wdata[3];
        // the unused mode code is refused so one of three modes holds
        if (reg_wdata[2:1] != 2'h3)
          ctrl_q.mode <= saq_pkg::saq_mode_t'(reg_wdata[2:1]);
      end
      if (hit(reg_addr, saq_pkg::OFS_CHSEL))
        chsel_q <= reg_wdata[4:0];
      if (hit(reg_addr, saq_pkg::OFS_TEN))
        ten_q <= reg_wdata[15:0];
      if (hit(reg_addr, saq_pkg::OFS_TSMP))
        tsmp_q <= reg_wdata[15:0];
      if (hit(reg_addr, saq_pkg::OFS_MASK))
        mask_q <= reg_wdata[1:0];
    end
  end

  assign auto_run = (run_mode_q != saq_pkg::MODE_SINGLE);
  assign abort = (state_q != saq_pkg::ST_IDLE) &&
                 (!ctrl_q.en || ctrl_q.mode != run_mode_q);
  assign slot_end = (slot_q >= saq_pkg::SLOT_W'(CH_PERIOD_CYC - 1));
  assign sweep_end = (state_q == saq_pkg::ST_SLOT) && slot_end &&
                     (ch_q == saq_pkg::AUTO_LAST) &&
                     (run_mode_q == saq_pkg::MODE_ONCE) && !abort;
  assign conv_done = sar_done && (state_q == saq_pkg::ST_CONVERT) && !abort;

  // warm-up, one-shot and pending-start bookkeeping
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      warm_q <= 1'b0;
      once_done_q <= 1'b0;
      single_req_q <= 1'b0;
    end else begin
      if (!ctrl_q.en)
        warm_q <= 1'b0;
      else if (state_q == saq_pkg::ST_ENWAIT &&
               cnt_q + 16'h0001 >= ten_q)
        warm_q <= 1'b1;
      if (!ctrl_q.en || ctrl_q.mode != saq_pkg::MODE_ONCE)
        once_done_q <= 1'b0;
      else if (sweep_end)
        once_done_q <= 1'b1;
      // a channel write is the start request of single mode
      if (reg_wr && hit(reg_addr, saq_pkg::OFS_CHSEL))
        single_req_q <= 1'b1;
      else if (state_q == saq_pkg::ST_IDLE && ctrl_q.en && warm_q &&
               ctrl_q.mode == saq_pkg::MODE_SINGLE)
        single_req_q <= 1'b0;
    end
  end

  // sequencing state machine
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= saq_pkg::ST_IDLE;
      run_mode_q <= saq_pkg::MODE_SINGLE;
      ch_q <= 5'h00;
      cnt_q <= 16'h0000;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      cnt_q <= cnt_q + 16'h0001;
      if (abort) begin
        state_q <= saq_pkg::ST_IDLE;
      end else begin
        case (state_q)
          saq_pkg::ST_IDLE: begin
            cnt_q <= 16'h0000;
            run_mode_q <= ctrl_q.mode;
            if (ctrl_q.en && !warm_q) begin
              state_q <= saq_pkg::ST_ENWAIT;
            end else if (ctrl_q.en) begin
              case (ctrl_q.mode)
                saq_pkg::MODE_SINGLE: begin
                  if (single_req_q) begin
                    ch_q <= chsel_q;
                    state_q <= saq_pkg::ST_SAMPLE;
                  end
                end
                saq_pkg::MODE_RROBIN: begin
                  ch_q <= 5'h00;
                  state_q <= saq_pkg::ST_SAMPLE;
                end
                saq_pkg::MODE_ONCE: begin
                  if (!once_done_q) begin
                    ch_q <= 5'h00;
                    state_q <= saq_pkg::ST_SAMPLE;
                  end
                end
                default: state_q <= saq_pkg::ST_IDLE;
              endcase
            end
          end
          saq_pkg::ST_ENWAIT: begin
            if (cnt_q + 16'h0001 >= ten_q)
              state_q <= saq_pkg::ST_IDLE;
          end
          saq_pkg::ST_SAMPLE: begin
            // a zero sample time still samples for one cycle
            if (cnt_q + 16'h0001 >= tsmp_q) begin
              go_q <= 1'b1;
              state_q <= saq_pkg::ST_CONVERT;
            end
          end
          saq_pkg::ST_CONVERT: begin
            cnt_q <= 16'h0000;
            if (sar_done)
              state_q <= saq_pkg::ST_INTA;
          end
          saq_pkg::ST_INTA: begin
            if (cnt_q == 16'(saq_pkg::INTA_CYC - 1)) begin
              cnt_q <= 16'h0000;
              if (auto_run)
                state_q <= saq_pkg::ST_SLOT;
              else if (ctrl_q.cont)
                state_q <= saq_pkg::ST_SAMPLE;
              else
                state_q <= saq_pkg::ST_IDLE;
            end
          end
          saq_pkg::ST_SLOT: begin
            cnt_q <= 16'h0000;
            if (slot_end) begin
              if (ch_q != saq_pkg::AUTO_LAST) begin
                ch_q <= ch_q + 5'h01;
                state_q <= saq_pkg::ST_SAMPLE;
              end else if (run_mode_q == saq_pkg::MODE_RROBIN) begin
                ch_q <= 5'h00;
                state_q <= saq_pkg::ST_SAMPLE;
              end else begin
                state_q <= saq_pkg::ST_IDLE;
              end
            end
          end
          default: state_q <= saq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // per-channel slot timer, restarted at every sample start
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q)
      slot_q <= 14'h0000;
    else if (state_q != saq_pkg::ST_SAMPLE || cnt_q == 16'h0000)
      slot_q <= (state_q == saq_pkg::ST_SAMPLE) ? 14'h0001 :
                slot_q + 14'h0001;
    else
      slot_q <= slot_q + 14'h0001;
  end

  saq_sar_engine u_sar (
    .mclk(mclk),
    .rst_n(rst_sync_q),
    .go(go_q),
    .clr(abort),
    .cmp_hi(cmp_hi),
    .dac_code(dac_code),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  // results: raw codes, 1.2 V full scale on divided voltage channels
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      last_q <= 10'h000;
      last_ch_q <= 5'h00;
      for (int i = 0; i < saq_pkg::NUM_AUTO; i++)
        res_q[i] <= 10'h000;
    end else if (conv_done) begin
      last_q <= sar_result;
      last_ch_q <= ch_q;
      if (auto_run && ch_q <= saq_pkg::AUTO_LAST)
        res_q[ch_q[3:0]] <= sar_result;
    end
  end

  assign stat_set = {sweep_end, conv_done};

  // sticky events; a new event beats a same-cycle write-one clear
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q)
      stat_q <= 2'h0;
    else if (reg_wr && hit(reg_addr, saq_pkg::OFS_STAT))
      stat_q <= (stat_q & ~reg_wdata[1:0]) | stat_set;
    else
      stat_q <= stat_q | stat_set;
  end

  // reads have no side effects, so sweeps continue undisturbed
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 32'h00000000;
    end else if (!reg_rd) begin
      rdata_q <= 32'h00000000;
    end else if (res_hit(reg_addr)) begin
      rdata_q <= {22'h000000, res_q[res_idx(reg_addr)]};
    end else begin
      case (reg_addr)
        saq_pkg::OFS_CTRL: rdata_q <= {28'h0000000, ctrl_q};
        saq_pkg::OFS_CHSEL: rdata_q <= {27'h0000000, chsel_q};
        saq_pkg::OFS_TEN: rdata_q <= {16'h0000, ten_q};
        saq_pkg::OFS_TSMP: rdata_q <= {16'h0000, tsmp_q};
        saq_pkg::OFS_STAT: rdata_q <= {30'h00000000, stat_q};
        saq_pkg::OFS_MASK: rdata_q <= {30'h00000000, mask_q};
        saq_pkg::OFS_STATE:
          rdata_q <= {20'h00000, sar_busy, once_done_q, warm_q,
                      state_q, ch_q, 1'b0};
        saq_pkg::OFS_LAST:
          rdata_q <= {11'h000, last_ch_q, 6'h00, last_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign mux_sel = ch_q;
  assign sample_en = (state_q == saq_pkg::ST_SAMPLE);
  assign done_irq = (state_q == saq_pkg::ST_INTA);
  assign irq = |(stat_q & mask_q);

  chk_done_two: assert property (@(posedge mclk) disable iff (!rst_sync_q ||
    abort) $rose(done_irq) |=> done_irq ##1 !done_irq)
    else $error("done interrupt not held for two cycles");
  chk_result_load: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    conv_done |=> last_q == $past(sar_result) && last_ch_q == $past(ch_q))
    else $error("completed result not captured");
  chk_auto_range: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    state_q == saq_pkg::ST_SAMPLE && auto_run |-> ch_q <= saq_pkg::AUTO_LAST)
    else $error("sweep reached a non-sequenced channel");
  chk_warm_after: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    $rose(warm_q) |-> $past(state_q) == saq_pkg::ST_ENWAIT)
    else $error("warm-up ended outside the enable delay");
  chk_abort_idle: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    abort |=> state_q == saq_pkg::ST_IDLE && $stable(last_q))
    else $error("abort did not stop or disturbed results");
  chk_sweep_irq: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    sweep_end |=> stat_q[saq_pkg::ST_SWEEP_BIT] &&
    state_q == saq_pkg::ST_IDLE)
    else $error("one-time sweep end not flagged");
  chk_rr_wrap: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    state_q == saq_pkg::ST_SLOT && slot_end && !abort &&
    ch_q == saq_pkg::AUTO_LAST && run_mode_q == saq_pkg::MODE_RROBIN
    |=> state_q == saq_pkg::ST_SAMPLE && ch_q == 5'h00)
    else $error("round-robin did not wrap to channel 0");
  chk_cont_restart: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    $fell(done_irq) && !auto_run && ctrl_q.cont && !abort &&
    !$past(abort) |-> state_q == saq_pkg::ST_SAMPLE)
    else $error("continuous single mode did not restart");
  chk_set_wins: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    conv_done |=> stat_q[saq_pkg::ST_CONV_BIT])
    else $error("conversion event lost");
  chk_sweep_store: assert property (@(posedge mclk) disable iff (!rst_sync_q)
    conv_done && auto_run |=> res_q[$past(ch_q[3:0])] == $past(sar_result))
    else $error("sweep result not overwritten");
endmodule : saq_sequencer

// ### saq_adc_model.sv
// comparator and input levels standing in for the analog mux and converter
`timescale 1ns/1ps
module saq_adc_model (
  // converter side
  input wire logic [saq_pkg::CH_W-1:0] mux_sel,
  input wire logic [saq_pkg::RES_W-1:0] dac_code,
  // level offset moved by the bench
  input wire logic [saq_pkg::RES_W-1:0] lvl_ofs,
  // comparator
  output logic cmp_hi
);
  logic [saq_pkg::RES_W-1:0] lvl;
  // each channel sits at its own fixed step of 0x21 codes per channel above the level offset
  assign lvl = lvl_ofs + {5'h00, mux_sel} * 10'h021;
  // half a code above the level, so no trial ever ties with the input
  assign cmp_hi = {lvl, 1'b1} > {dac_code, 1'b0};
endmodule : saq_adc_model

// ### tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb;
  localparam int PER = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [saq_pkg::ADDR_W-1:0] reg_addr = 8'h00;
  logic [saq_pkg::DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [saq_pkg::DATA_W-1:0] reg_rdata;
  logic [saq_pkg::CH_W-1:0] mux_sel;
  logic [saq_pkg::RES_W-1:0] dac_code;
  logic [saq_pkg::RES_W-1:0] lvl_ofs = 10'h015;
  logic sample_en;
  logic cmp_hi;
  logic done_irq;
  logic irq;
  logic se_d = 1'b0;
  logic dn_d = 1'b0;
  logic [31:0] rv;
  logic [4:0] chq[$];
  int riseq[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_srise, t_sfall, t_drise, t_dfall, t_wr, nd;
  int n_done = 0;

  always #2.5 mclk = ~mclk;

  saq_sequencer #(.CH_PERIOD_CYC(PER)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mux_sel(mux_sel), .sample_en(sample_en),
    .dac_code(dac_code), .cmp_hi(cmp_hi), .done_irq(done_irq), .irq(irq)
  );

  saq_adc_model adc (
    .mux_sel(mux_sel), .dac_code(dac_code), .lvl_ofs(lvl_ofs),
    .cmp_hi(cmp_hi)
  );

  // edge timestamps; values seen here are those of the cycle just ended
  always @(posedge mclk) begin
    cyc++;
    if (sample_en === 1'b1 && se_d === 1'b0) begin
      t_srise = cyc;
      chq.push_back(mux_sel);
      riseq.push_back(cyc);
    end
    if (sample_en === 1'b0 && se_d === 1'b1) t_sfall = cyc;
    if (done_irq === 1'b1 && dn_d === 1'b0) t_drise = cyc;
    if (done_irq === 1'b0 && dn_d === 1'b1) begin
      t_dfall = cyc;
      n_done++;
    end
    se_d = sample_en;
    dn_d = done_irq;
  end

  function automatic logic [9:0] lvl(input int ch);
    return lvl_ofs + 10'(ch) * 10'h021;
  endfunction : lvl

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdck

  task automatic irqck(input logic exp);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irqck

  // bounded wait, a stuck sequencer shows up as a count mismatch
  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && n_done < n; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask : wait_done

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rdck(saq_pkg::OFS_CTRL, 32'h0);
    rdck(saq_pkg::OFS_TEN, {16'h0, saq_pkg::TEN_RST});
    rdck(saq_pkg::OFS_TSMP, {16'h0, saq_pkg::TSMP_RST});
    rdck(saq_pkg::OFS_MASK, 32'h0);
    rdck(8'h3C, 32'h0);
    $display("test reset done");
    // single shot on the divide-by-2 view of a config pin
    wr(saq_pkg::OFS_TSMP, 32'h3);
    wr(saq_pkg::OFS_TEN, 32'h14);
    wr(saq_pkg::OFS_MASK, 32'h1);
    t_wr = cyc;
    wr(saq_pkg::OFS_CTRL, 32'h1);
    wr(saq_pkg::OFS_CHSEL, 32'hC);
    wait_done(1);
    chk(t_srise - t_wr >= 20 && t_srise - t_wr < 28, 1);
    chk(t_sfall - t_srise, 3);
    chk(t_drise - t_sfall, 12);
    chk(t_dfall - t_drise, 2);
    chk(chq[$], 5'hC);
    rdck(saq_pkg::OFS_LAST, {11'h0, 5'hC, 6'h0, lvl(12)});
    rdck(saq_pkg::OFS_LAST, {11'h0, 5'hC, 6'h0, lvl(12)});
    rdck(saq_pkg::OFS_STAT, 32'h1);
    irqck(1'b1);
    wr(saq_pkg::OFS_MASK, 32'h0);
    irqck(1'b0);
    wr(saq_pkg::OFS_MASK, 32'h1);
    irqck(1'b1);
    wr(saq_pkg::OFS_STAT, 32'h1);
    irqck(1'b0);
    repeat (60) @(posedge mclk);
    chk(n_done, 1);
    $display("test single done");
    // continuous single, then disable while busy
    wr(saq_pkg::OFS_CTRL, 32'h9);
    wr(saq_pkg::OFS_CHSEL, 32'h5);
    wait_done(3);
    chk(t_srise, t_dfall);
    chk(chq[$], 5'h5);
    for (int i = 0; i < 100 && sample_en !== 1'b1; i++) @(posedge mclk);
    nd = n_done;
    wr(saq_pkg::OFS_CTRL, 32'h0);
    repeat (60) @(posedge mclk);
    chk(n_done, nd);
    rdck(saq_pkg::OFS_LAST, {11'h0, 5'h5, 6'h0, lvl(5)});
    $display("test continuous done");
    // round robin, reading results while it runs
    chq.delete();
    riseq.delete();
    wr(saq_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 100 && chq.size() < 14; i++) begin
      rd(saq_pkg::OFS_RES0 + 8'(4 * (i % 11)), rv);
      repeat (8) @(posedge mclk);
    end
    for (int k = 0; k < 11; k++) begin
      rdck(saq_pkg::OFS_RES0 + 8'(4 * k), {22'h0, lvl(k)});
    end
    lvl_ofs <= 10'h140;
    repeat (12 * PER + 20) @(posedge mclk);
    for (int k = 0; k < 11; k++) begin
      rdck(saq_pkg::OFS_RES0 + 8'(4 * k), {22'h0, lvl(k)});
    end
    wr(saq_pkg::OFS_CTRL, 32'h1);
    repeat (40) @(posedge mclk);
    for (int k = 0; k < 11; k++) begin
      rdck(saq_pkg::OFS_RES0 + 8'(4 * k), {22'h0, lvl(k)});
    end
    chk(chq.size() >= 24, 1);
    for (int i = 0; i < chq.size() - 1; i++) begin
      chk(chq[i], 5'(i % 11));
      chk(riseq[i + 1] - riseq[i], PER);
    end
    $display("test round robin done");
    // one-time sweep
    wr(saq_pkg::OFS_CTRL, 32'h0);
    wr(saq_pkg::OFS_STAT, 32'h3);
    wr(saq_pkg::OFS_MASK, 32'h2);
    chq.delete();
    wr(saq_pkg::OFS_CTRL, 32'h5);
    repeat (11 * PER + 300) @(posedge mclk);
    chk(chq.size(), 11);
    chk(chq[10], 5'hA);
    rd(saq_pkg::OFS_STAT, rv);
    chk(rv[1], 1'b1);
    irqck(1'b1);
    // idle, sweep finished, warm, channel 10 still addressed
    rdck(saq_pkg::OFS_STATE, 32'h00000614);
    // the unused mode code must leave the one-time mode in place
    wr(saq_pkg::OFS_CTRL, 32'h7);
    rdck(saq_pkg::OFS_CTRL, 32'h5);
    $display("test one-time done");
    report_and_stop();
  end
endmodule : tb
